// *** design/mbls_map.svh ***
/*
 * Constants of the memory-bus lane steering block: widths, encodings,
 * idle pin levels and synchroniser depth.
 * Assumes it is included by the package and by the steering module.
 */
`ifndef MBLS_MAP_SVH
`define MBLS_MAP_SVH

`define MBLS_HI_W        16
`define MBLS_HI_LSB      16
`define MBLS_HI_MSB      31
`define MBLS_DATA_W      32
`define MBLS_LANES       4
`define MBLS_SYNC_DEPTH  3

`define MBLS_KIND_W      3
`define MBLS_KIND_IDLE   3'h0
`define MBLS_KIND_SDRAM  3'h1
`define MBLS_KIND_IO32   3'h2
`define MBLS_KIND_IO16   3'h3
`define MBLS_KIND_ROM    3'h4

`define MBLS_BANK_W      2
`define MBLS_BANK0       2'h0
`define MBLS_BANK1       2'h1
`define MBLS_BANK2       2'h2
`define MBLS_BANK3       2'h3

`define MBLS_MASK_IDLE   1'h1
`define MBLS_CS_IDLE     1'h1
`define MBLS_STRAP_RST   1'h0

`endif

// *** design/mbls_pkg.sv ***
/*
 * Types of the memory-bus lane steering block.
 * Assumes mbls_map.svh is on the include path.
 */
`include "mbls_map.svh"

package mbls_pkg;

    typedef enum logic [`MBLS_KIND_W-1:0] {
        MBLS_IDLE  = `MBLS_KIND_IDLE,
        MBLS_SDRAM = `MBLS_KIND_SDRAM,
        MBLS_IO32  = `MBLS_KIND_IO32,
        MBLS_IO16  = `MBLS_KIND_IO16,
        MBLS_ROM   = `MBLS_KIND_ROM
    } mbls_kind_t;

    // One bus cycle as the memory controller asks for it.
    typedef struct packed {
        mbls_kind_t                    kind;
        logic                          sdram_cmd;
        logic [`MBLS_BANK_W-1:0]       bank;
        logic [`MBLS_LANES-1:0]        lane_mask;
        logic                          addr_low;
        logic                          high_byte_en;
        logic                          big_endian;
        logic [`MBLS_DATA_W-1:0]       wdata;
        logic                          data_drive;
    } mbls_req_t;

    // Pin-side levels of the steered select and mask outputs.
    typedef struct packed {
        logic                          byte_mask_three;
        logic                          byte_mask_two;
        logic                          byte_mask_one;
        logic                          byte_mask_zero;
        logic [1:0]                    cs_n;
        logic [1:0]                    shared_cs_n;
        logic [1:0]                    cke;
    } mbls_pins_t;

endpackage : mbls_pkg

// *** design/mbls_steer.sv ***
/*
 * Memory-bus lane steering: chooses what the upper data lines, the four
 * byte-mask pins, the chip selects and the clock enables carry, from the
 * bus-width strap and the kind of access in progress.
 * Assumes a memory controller on core_clk supplies one request a cycle
 * and that the pad ring resolves pin levels from the output enables.
 */
// Functional notes
// - Strap high: the upper sixteen lines carry data bits 16 to 31.
// - Strap low: the upper sixteen lines serve as general I/O pins.
// - Clock enable 0 covers banks 0 and 2, enable 1 banks 1 and 3.
// - Strap high: mask three enables lane 24..31, SDRAM and 32-bit I/O.
// - Strap high: mask two enables lane 16..23, SDRAM and 32-bit I/O.
// - Strap low: mask three selects the SDRAM at bank 3 on a command.
// - Strap low: mask two selects the SDRAM at bank 2 on a command.
// - Wide bus, extended SDRAM fitted: banks 2/3 use shared selects 2/3, banks 0/1 selects 0/1.
// - Mask one enables lane 8..15 for SDRAM and 32-bit I/O.
// - 16-bit I/O: mask one is addr bit 0 if little, high enable if big.
// - Mask zero enables lane 0..7; for 16-bit I/O it swaps with mask one.
// - Shared selects 2/3 serve extended SDRAM if fitted on a wide bus, or extended ROM if fitted without extended SDRAM.
`timescale 1ns/1ps
`include "mbls_map.svh"

module mbls_steer (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    // Strap and board configuration.
    input  wire logic                       wide_bus_strap,
    input  wire logic                       ext_sdram_fitted,
    input  wire logic                       ext_rom_fitted,
    // Memory controller request.
    input  wire mbls_pkg::mbls_req_t        req,
    input  wire logic [3:0]                 cke_req,
    input  wire logic [1:0]                 ext_rom_sel,
    // General I/O logic for the upper lines.
    input  wire logic [`MBLS_HI_W-1:0]      gpio_out,
    input  wire logic [`MBLS_HI_W-1:0]      gpio_oe,
    output      logic [`MBLS_HI_W-1:0]      gpio_in,
    // Read data for the upper half of the bus.
    output      logic [`MBLS_HI_W-1:0]      rdata_hi,
    // Upper data pins.
    input  wire logic [`MBLS_HI_W-1:0]      data_hi_pin_in,
    output      logic [`MBLS_HI_W-1:0]      data_hi_pin_out,
    output      logic [`MBLS_HI_W-1:0]      data_hi_pin_oe,
    // Steered select, mask and clock-enable pins.
    output      mbls_pkg::mbls_pins_t       pins,
    // Status.
    output      logic                       wide_bus
);

    logic [`MBLS_SYNC_DEPTH-1:0] strap_sync;
    logic [`MBLS_HI_W-1:0]       hi_s1;
    logic [`MBLS_HI_W-1:0]       hi_s2;
    logic [`MBLS_HI_W-1:0]       hi_s3;
    logic [`MBLS_HI_W-1:0]       hi_stable;
    logic                        is_sdram_cmd;
    logic                        lane_kind;
    mbls_pkg::mbls_pins_t        next_pins;

    // Selects are active low: low when the command targets bank b.
    function automatic logic bank_sel_n(
        input logic       cmd,
        input logic [1:0] bank,
        input logic [1:0] which
    );
        bank_sel_n = ~(cmd && (bank == which));
    endfunction : bank_sel_n

    // A bit takes its synchronised level only once two stages agree, so a
    // line caught mid-change never shows a half-settled value.
    function automatic logic [`MBLS_HI_W-1:0] settle(
        input logic [`MBLS_HI_W-1:0] now_lvl,
        input logic [`MBLS_HI_W-1:0] agree,
        input logic [`MBLS_HI_W-1:0] held
    );
        settle = (now_lvl & agree) | (held & ~agree);
    endfunction : settle

    // The strap is a pin: three stages, then taken once stages two and
    // three agree, so a slow or bouncing strap never flips mid-cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            strap_sync <= {`MBLS_SYNC_DEPTH{`MBLS_STRAP_RST}};
        end else begin
            strap_sync <= {strap_sync[1:0], wide_bus_strap};
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wide_bus <= `MBLS_STRAP_RST;
        end else if (strap_sync[1] == strap_sync[2]) begin
            wide_bus <= strap_sync[2];
        end
    end

    // Upper pins pass the same three-stage chain before any use.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hi_s1 <= 16'h0000;
            hi_s2 <= 16'h0000;
            hi_s3 <= 16'h0000;
        end else begin
            hi_s1 <= data_hi_pin_in;
            hi_s2 <= hi_s1;
            hi_s3 <= hi_s2;
        end
    end

    assign hi_stable = ~(hi_s2 ^ hi_s3);

    // Only the owner of the lines sees their level; the other reads zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_hi <= 16'h0000;
            gpio_in  <= 16'h0000;
        end else if (wide_bus) begin
            rdata_hi <= settle(hi_s3, hi_stable, rdata_hi);
            gpio_in  <= 16'h0000;
        end else begin
            rdata_hi <= 16'h0000;
            gpio_in  <= settle(hi_s3, hi_stable, gpio_in);
        end
    end

    // Upper pin drivers.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            data_hi_pin_out <= 16'h0000;
            data_hi_pin_oe  <= 16'h0000;
        end else if (wide_bus) begin
            data_hi_pin_out <=
                req.wdata[`MBLS_HI_MSB:`MBLS_HI_LSB];
            data_hi_pin_oe  <= {`MBLS_HI_W{req.data_drive}};
        end else begin
            data_hi_pin_out <= gpio_out;
            data_hi_pin_oe  <= gpio_oe;
        end
    end

    assign is_sdram_cmd = (req.kind == mbls_pkg::MBLS_SDRAM) && req.sdram_cmd;
    assign lane_kind    = (req.kind == mbls_pkg::MBLS_SDRAM)
                       || (req.kind == mbls_pkg::MBLS_IO32)
                       || (req.kind == mbls_pkg::MBLS_ROM);

    always_comb begin
        next_pins = '{
            byte_mask_three: `MBLS_MASK_IDLE,
            byte_mask_two:   `MBLS_MASK_IDLE,
            byte_mask_one:   `MBLS_MASK_IDLE,
            byte_mask_zero:  `MBLS_MASK_IDLE,
            cs_n:            {2{`MBLS_CS_IDLE}},
            shared_cs_n:     {2{`MBLS_CS_IDLE}},
            cke:             2'h0
        };
        next_pins.cke[0] = cke_req[0] | cke_req[2];
        next_pins.cke[1] = cke_req[1] | cke_req[3];
        next_pins.cs_n[0] = bank_sel_n(is_sdram_cmd, req.bank, `MBLS_BANK0);
        next_pins.cs_n[1] = bank_sel_n(is_sdram_cmd, req.bank, `MBLS_BANK1);
        if (lane_kind) begin
            next_pins.byte_mask_one  = req.lane_mask[1];
            next_pins.byte_mask_zero = req.lane_mask[0];
        end else if (req.kind == mbls_pkg::MBLS_IO16) begin
            if (req.big_endian) begin
                next_pins.byte_mask_one  = req.high_byte_en;
                next_pins.byte_mask_zero = req.addr_low;
            end else begin
                next_pins.byte_mask_one  = req.addr_low;
                next_pins.byte_mask_zero = req.high_byte_en;
            end
        end
        if (wide_bus) begin
            if (lane_kind) begin
                next_pins.byte_mask_three = req.lane_mask[3];
                next_pins.byte_mask_two   = req.lane_mask[2];
            end
            if (ext_sdram_fitted) begin
                next_pins.shared_cs_n[0] = bank_sel_n(
                    is_sdram_cmd, req.bank, `MBLS_BANK2);
                next_pins.shared_cs_n[1] = bank_sel_n(
                    is_sdram_cmd, req.bank, `MBLS_BANK3);
            end
        end else begin
            // Narrow bus: the two upper masks become bank 2/3 selects.
            next_pins.byte_mask_three =
                bank_sel_n(is_sdram_cmd, req.bank, `MBLS_BANK3);
            next_pins.byte_mask_two =
                bank_sel_n(is_sdram_cmd, req.bank, `MBLS_BANK2);
        end
        // Extended ROM takes the shared selects only when no extended SDRAM
        // claims them, so the two can never fight on one pin.
        if (ext_rom_fitted && !ext_sdram_fitted
                && req.kind == mbls_pkg::MBLS_ROM) begin
            next_pins.shared_cs_n = ~ext_rom_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pins <= '{
                byte_mask_three: `MBLS_MASK_IDLE,
                byte_mask_two:   `MBLS_MASK_IDLE,
                byte_mask_one:   `MBLS_MASK_IDLE,
                byte_mask_zero:  `MBLS_MASK_IDLE,
                cs_n:            {2{`MBLS_CS_IDLE}},
                shared_cs_n:     {2{`MBLS_CS_IDLE}},
                cke:             2'h0
            };
        end else begin
            pins <= next_pins;
        end
    end

    // Checks.

    sequence s_wide_data;
        wide_bus && req.data_drive;
    endsequence

    property p_wide_drive;
        @(posedge core_clk) disable iff (sys_rst)
        s_wide_data |=> (data_hi_pin_oe == 16'hFFFF)
            && (data_hi_pin_out == $past(req.wdata[31:16]));
    endproperty
    a_wide_drive: assert property (p_wide_drive)
        else $error("upper lines not carrying write data in wide mode");

    property p_narrow_gpio;
        @(posedge core_clk) disable iff (sys_rst)
        !wide_bus |=> (data_hi_pin_oe == $past(gpio_oe))
            && (data_hi_pin_out == $past(gpio_out)) && (rdata_hi == 16'h0000);
    endproperty
    a_narrow_gpio: assert property (p_narrow_gpio)
        else $error("upper lines not handed to general I/O in narrow mode");

    property p_cke_pair;
        @(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> pins.cke == {$past(cke_req[1] | cke_req[3]),
                              $past(cke_req[0] | cke_req[2])};
    endproperty
    a_cke_pair: assert property (p_cke_pair)
        else $error("clock enable does not follow its bank pair");

    sequence s_wide_lane;
        wide_bus && (req.kind == mbls_pkg::MBLS_SDRAM
            || req.kind == mbls_pkg::MBLS_IO32);
    endsequence

    property p_mask_three_lane;
        @(posedge core_clk) disable iff (sys_rst)
        s_wide_lane |=> pins.byte_mask_three == $past(req.lane_mask[3]);
    endproperty
    a_mask_three_lane: assert property (p_mask_three_lane)
        else $error("byte mask three not lane 24..31 in wide mode");

    property p_mask_two_lane;
        @(posedge core_clk) disable iff (sys_rst)
        s_wide_lane |=> pins.byte_mask_two == $past(req.lane_mask[2]);
    endproperty
    a_mask_two_lane: assert property (p_mask_two_lane)
        else $error("byte mask two not lane 16..23 in wide mode");

    sequence s_narrow_cmd(logic [1:0] b);
        !wide_bus && is_sdram_cmd && req.bank == b;
    endsequence

    property p_mask_three_cs;
        @(posedge core_clk) disable iff (sys_rst)
        s_narrow_cmd(2'h3) |=> !pins.byte_mask_three && pins.byte_mask_two;
    endproperty
    a_mask_three_cs: assert property (p_mask_three_cs)
        else $error("byte mask three not selecting bank 3");

    property p_mask_two_cs;
        @(posedge core_clk) disable iff (sys_rst)
        s_narrow_cmd(2'h2) |=> !pins.byte_mask_two && pins.byte_mask_three;
    endproperty
    a_mask_two_cs: assert property (p_mask_two_cs)
        else $error("byte mask two not selecting bank 2");

    property p_wide_shared_cs;
        @(posedge core_clk) disable iff (sys_rst)
        wide_bus && ext_sdram_fitted && is_sdram_cmd && req.bank[1]
            |=> pins.shared_cs_n == ~{$past(req.bank[0]), !$past(req.bank[0])}
                && pins.cs_n == 2'h3;
    endproperty
    a_wide_shared_cs: assert property (p_wide_shared_cs)
        else $error("bank 2/3 command not on shared selects");

    property p_mask_one;
        @(posedge core_clk) disable iff (sys_rst)
        (req.kind == mbls_pkg::MBLS_IO16) |=> pins.byte_mask_one ==
            ($past(req.big_endian) ? $past(req.high_byte_en)
                                   : $past(req.addr_low));
    endproperty
    a_mask_one: assert property (p_mask_one)
        else $error("byte mask one wrong for 16-bit I/O");

    property p_mask_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (req.kind == mbls_pkg::MBLS_IO16) |=> pins.byte_mask_zero ==
            ($past(req.big_endian) ? $past(req.addr_low)
                                   : $past(req.high_byte_en));
    endproperty
    a_mask_zero: assert property (p_mask_zero)
        else $error("byte mask zero wrong for 16-bit I/O");

    property p_low_lanes;
        @(posedge core_clk) disable iff (sys_rst)
        (req.kind == mbls_pkg::MBLS_SDRAM || req.kind == mbls_pkg::MBLS_IO32)
            |=> {pins.byte_mask_one, pins.byte_mask_zero}
                == $past(req.lane_mask[1:0]);
    endproperty
    a_low_lanes: assert property (p_low_lanes)
        else $error("low byte masks not lanes 0..15");

    property p_rom_shared;
        @(posedge core_clk) disable iff (sys_rst)
        ext_rom_fitted && !ext_sdram_fitted
            && req.kind == mbls_pkg::MBLS_ROM
            |=> pins.shared_cs_n == ~$past(ext_rom_sel);
    endproperty
    a_rom_shared: assert property (p_rom_shared)
        else $error("shared selects not serving extended ROM");

endmodule : mbls_steer

// *** sim/mbls_mem_model.sv ***
/*
 * Model of the memories on the upper data lines: resolves the line level
 * from the steering block's drive and the memory's read drive.
 * Assumes the bench raises mem_drive only while the block is not driving.
 */
`timescale 1ns/1ps

module mbls_mem_model (
    // Clock.
    input  wire logic        core_clk,
    // Steering block side of the upper lines.
    input  wire logic [15:0] dev_out,
    input  wire logic [15:0] dev_oe,
    // Memory read drive.
    input  wire logic        mem_drive,
    input  wire logic [15:0] mem_data,
    // Resolved line level.
    output      logic [15:0] line
);
    logic [15:0] last = 16'h0000;

    // Released lines have no pull, so they toggle rather than hold a value.
    // A plain process: the start value must stay, or the toggle stays unknown.
    always @(posedge core_clk) begin
        last <= line;
    end

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (dev_oe[i])
                line[i] = dev_out[i];
            else if (mem_drive)
                line[i] = mem_data[i];
            else
                line[i] = ~last[i];
        end
    end
endmodule : mbls_mem_model

// *** sim/memory_bus_lane_steering_tb.sv ***
/*
 * Self-checking bench for the lane steering block with random requests.
 * Assumes the design package and mbls_mem_model are compiled first.
 */
`timescale 1ns/1ps

module memory_bus_lane_steering_tb;
    logic core_clk = 1'h0;
    logic sys_rst  = 1'h1;
    logic strap    = 1'h0;
    logic sdf, rf, mdrv, wide_bus;
    mbls_pkg::mbls_req_t  req;
    mbls_pkg::mbls_pins_t pins, ep;
    logic [3:0]  cke_req;
    logic [1:0]  rom_sel;
    logic [15:0] gpio_out, gpio_oe, gpio_in, rdata_hi, pin_in, pin_out;
    logic [15:0] pin_oe, mdata, eoe, eout;
    logic [31:0] r;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    mbls_steer u_mbls_steer (.core_clk(core_clk), .sys_rst(sys_rst),
        .wide_bus_strap(strap), .ext_sdram_fitted(sdf),
        .ext_rom_fitted(rf), .req(req), .cke_req(cke_req),
        .ext_rom_sel(rom_sel), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_in(gpio_in), .rdata_hi(rdata_hi), .data_hi_pin_in(pin_in),
        .data_hi_pin_out(pin_out), .data_hi_pin_oe(pin_oe), .pins(pins),
        .wide_bus(wide_bus));

    mbls_mem_model u_mbls_mem_model (.core_clk(core_clk), .dev_out(pin_out),
        .dev_oe(pin_oe), .mem_drive(mdrv), .mem_data(mdata), .line(pin_in));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    function automatic mbls_pkg::mbls_pins_t exp_pins(input logic w);
        mbls_pkg::mbls_pins_t p;
        logic lane, io16, c2, c3;
        lane = req.kind inside {mbls_pkg::MBLS_SDRAM, mbls_pkg::MBLS_IO32,
                                mbls_pkg::MBLS_ROM};
        io16 = req.kind == mbls_pkg::MBLS_IO16;
        c2 = req.sdram_cmd && req.bank == 2'h2;
        c3 = req.sdram_cmd && req.bank == 2'h3;
        p.cke = {cke_req[1] | cke_req[3], cke_req[0] | cke_req[2]};
        p.cs_n = ~{req.sdram_cmd && req.bank == 2'h1,
                   req.sdram_cmd && req.bank == 2'h0};
        p.byte_mask_three = w ? (lane ? req.lane_mask[3] : 1'h1) : ~c3;
        p.byte_mask_two = w ? (lane ? req.lane_mask[2] : 1'h1) : ~c2;
        p.byte_mask_one = lane ? req.lane_mask[1] : !io16 ? 1'h1 :
            (req.big_endian ? req.high_byte_en : req.addr_low);
        p.byte_mask_zero = lane ? req.lane_mask[0] : !io16 ? 1'h1 :
            (req.big_endian ? req.addr_low : req.high_byte_en);
        if (w && sdf)
            p.shared_cs_n = ~{c3, c2};
        else if (!sdf && rf && req.kind == mbls_pkg::MBLS_ROM)
            p.shared_cs_n = ~rom_sel;
        else
            p.shared_cs_n = 2'h3;
        return p;
    endfunction : exp_pins

    task automatic rnd_req();
        r = $urandom;
        {gpio_out, gpio_oe} = r;
        req.wdata = $urandom;
        r = $urandom;
        {req.bank, req.lane_mask, req.addr_low, req.high_byte_en,
         req.big_endian, req.data_drive, cke_req, rom_sel, sdf, rf} = r[17:0];
        req.kind = mbls_pkg::mbls_kind_t'(r[30:28] % 3'h5);
        req.sdram_cmd = r[31] && req.kind == mbls_pkg::MBLS_SDRAM;
    endtask : rnd_req

    // Compares every steered output with what the last request should give.
    task automatic chk_pins();
        chk("cke", pins.cke, ep.cke);
        chk("cs", pins.cs_n, ep.cs_n);
        chk("shared_cs", pins.shared_cs_n, ep.shared_cs_n);
        chk("mask3", pins.byte_mask_three, ep.byte_mask_three);
        chk("mask2", pins.byte_mask_two, ep.byte_mask_two);
        chk("mask1", pins.byte_mask_one, ep.byte_mask_one);
        chk("mask0", pins.byte_mask_zero, ep.byte_mask_zero);
        chk("data_oe", pin_oe, eoe);
        chk("data_out", pin_out, eout);
    endtask : chk_pins

    // Each request is checked one cycle after it is driven, the last too.
    task automatic run_mode(input logic w, input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge core_clk);
            if (i > 0) begin
                chk_pins();
            end
            if (i == n) begin
                break;
            end
            rnd_req();
            if (i == 0) begin
                // Awkward corner first: a bank 3 command with extra SDRAM.
                req.kind = mbls_pkg::MBLS_SDRAM;
                req.sdram_cmd = 1'h1;
                req.bank = 2'h3;
                sdf = 1'h1;
            end
            ep = exp_pins(w);
            eoe = w ? (req.data_drive ? 16'hFFFF : 16'h0000) : gpio_oe;
            eout = w ? req.wdata[31:16] : gpio_out;
        end
        $display("test requests wide=%0d done", w);
    endtask : run_mode

    task automatic set_strap(input logic w);
        @(negedge core_clk);
        strap = w;
        repeat (5) @(negedge core_clk);
        chk("wide_bus", wide_bus, w);
        $display("test strap %0d done", w);
    endtask : set_strap

    task automatic rd_test(input logic w);
        @(negedge core_clk);
        req = '0;
        gpio_oe = 16'h0000;
        r = $urandom;
        mdata = r[15:0];
        mdrv = 1'h1;
        repeat (6) @(negedge core_clk);
        chk("rdata_hi", rdata_hi, w ? mdata : 16'h0000);
        chk("gpio_in", gpio_in, w ? 16'h0000 : mdata);
        mdrv = 1'h0;
        $display("test read wide=%0d done", w);
    endtask : rd_test

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            $display("timeout after %0d cycles", cyc);
            results();
        end
    end

    initial begin
        req = '0;
        {sdf, rf, mdrv} = 3'h0;
        {cke_req, rom_sel} = 6'h00;
        {gpio_out, gpio_oe, mdata} = 48'h0;
        r = $urandom(96);
        repeat (3) @(negedge core_clk);
        chk("reset_pins", pins, 10'h3FC);
        chk("reset_oe", pin_oe, 16'h0000);
        sys_rst = 1'h0;
        $display("test reset done");
        set_strap(1'h0);
        run_mode(1'h0, 300);
        rd_test(1'h0);
        set_strap(1'h1);
        run_mode(1'h1, 300);
        rd_test(1'h1);
        results();
    end
endmodule : memory_bus_lane_steering_tb
